// ---- core/pmc_power_mode_controller.sv ----
// Power mode controller: backup write gate, supply detector selection,
// Sleep/Stop/Standby sequencing, wake pin, backup regulator flags.
// Assumes all inputs synchronous to clk_sys and a simple peripheral-bus
// slave with setup and access phases (psel, penable, pready).
`timescale 1ns/1ps
module pmc_power_mode_controller
   import pmc_pkg::*;
#(
   parameter int ADDR_W         = 8,
   parameter int FLASH_WAKE     = FLASH_WAKE_CYC,
   parameter int LPREG_WAKE     = LPREG_WAKE_CYC
)(
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   input  wire logic                  periphReset,
   // Register bus
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [ADDR_W-1:0]     paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Core handshake
   input  wire logic                  cpuWaitReq,
   input  wire logic                  cpuDeepSleep,
   input  wire logic                  irqAck,
   input  wire logic                  eventLineAny,
   // Wake sources
   input  wire logic                  wakePin,
   input  wire pmc_wake_src_t         wakeSrc,
   // Supply detector and regulators
   input  wire logic [DET_LEVELS-1:0] supplyAbove,
   input  wire logic                  backupRegReadyIn,
   input  wire logic                  rdpDowngradeReq,
   output logic      [2:0]            detectLevelSel,
   output logic                       detectorEnable,
   output logic                       eventLine16,
   output logic                       wakePinPullDown,
   output logic                       backupRegEnable,
   output logic                       backupWriteEnable,
   output logic                       backupSramErase,
   output pmc_power_t                 powerCtl,
   output pmc_mode_t                  powerMode
);

   // Elaboration-time refusal of unsupported address widths and wake counts
   if (ADDR_W < 3 || FLASH_WAKE < 1 || LPREG_WAKE < 1 ||
       FLASH_WAKE >= (1 << WAKE_CNT_W) || LPREG_WAKE >= (1 << WAKE_CNT_W))
   begin : g_badParam
      $error("pmc_power_mode_controller: unsupported parameter value");
   end

   // Registers
   logic            stopLp_q, pdds_q, pvde_q, dbp_q, flashPd_q;
   logic [2:0]      level_q;
   logic            wakeFlag_q, stbyFlag_q, pinEn_q, bre_q;
   logic            pinLast_q;
   logic [31:0]     rdata_q;
   pmc_mode_t       mode_q, mode_d;
   logic [WAKE_CNT_W-1:0] wakeCnt_q, wakeCnt_d;

   // Bus decode
   wire logic       setupPhase  = psel & ~penable;
   wire logic       accessPhase = psel & penable;
   wire logic       hitCtrl     = (paddr == ADDR_W'(OFS_CTRL));
   wire logic       hitStat     = (paddr == ADDR_W'(OFS_CTRL_STAT));
   wire logic       hitAny      = hitCtrl | hitStat;
   wire logic       wrCtrl      = accessPhase & pwrite & hitCtrl;
   wire logic       wrStat      = accessPhase & pwrite & hitStat;

   // Supply detector: flag set while enabled outside Standby and the supply sits below the threshold
   wire logic       detActive   = pvde_q & (mode_q != PMC_STANDBY);
   wire logic       belowLevel  = ~supplyAbove[level_q];
   wire logic       detFlag     = detActive & belowLevel;

   // Wake pin edges; pins are synchronous so a single stage suffices
   wire logic       pinRise     = pinEn_q & wakePin & ~pinLast_q;
   wire logic       pinEnOnHigh = wrStat & pwdata[STAT_PIN_EN_BIT] & ~pinEn_q & wakePin;
   wire logic       rtcWake     = wakeSrc.rtcAlarmA | wakeSrc.rtcAlarmB | wakeSrc.rtcWakeup |
                                  wakeSrc.rtcTamper | wakeSrc.rtcTimeStamp;
   wire logic       wakeEvent   = pinRise | rtcWake | pinEnOnHigh;
   wire logic       standbyExit = pinRise | rtcWake | wakeSrc.resetPin |
                                  wakeSrc.watchdogReset;
   wire logic       leaveStandby = (mode_q == PMC_STANDBY) & standbyExit;

   // Control register images
   wire logic [31:0] ctrlImage =
        (32'h1 << CTRL_STOP_LP_BIT) * {31'h0, stopLp_q} |
        (32'h1 << CTRL_PDDS_BIT) * {31'h0, pdds_q} |
        (32'h1 << CTRL_PVDE_BIT) * {31'h0, pvde_q} |
        ({29'h0, level_q} << CTRL_LEVEL_LSB) |
        (32'h1 << CTRL_DBP_BIT)  * {31'h0, dbp_q} |
        (32'h1 << CTRL_FLASH_PD_BIT) * {31'h0, flashPd_q};
   // Ready flag comes straight from the regulator, so no reset can clear it
   wire logic [31:0] statImage =
        (32'h1 << STAT_WAKE_FLAG_BIT) * {31'h0, wakeFlag_q} |
        (32'h1 << STAT_STBY_FLAG_BIT) * {31'h0, stbyFlag_q} |
        (32'h1 << STAT_DET_FLAG_BIT)  * {31'h0, detFlag} |
        (32'h1 << STAT_READY_BIT) * {31'h0, backupRegReadyIn} |
        (32'h1 << STAT_PIN_EN_BIT) * {31'h0, pinEn_q} |
        (32'h1 << STAT_BRE_BIT)  * {31'h0, bre_q};
   wire logic [31:0] readMux = hitCtrl ? ctrlImage : (hitStat ? statImage : 32'h0);

   // Clear strobes; a new event in the same cycle wins over the clear
   wire logic       clrWake     = wrCtrl & pwdata[CTRL_CWUF_BIT];
   wire logic       clrStby     = wrCtrl & pwdata[CTRL_CSBF_BIT];

   // Control words lost in Standby or on a peripheral reset
   wire logic       ctrlDefault = periphReset | leaveStandby;

   // Startup delay out of Stop depends on what was powered down
   wire logic [WAKE_CNT_W-1:0] flashDelay = flashPd_q ? WAKE_CNT_W'(FLASH_WAKE) : '0;
   wire logic [WAKE_CNT_W-1:0] lpDelay    = stopLp_q ? WAKE_CNT_W'(LPREG_WAKE) : '0;
   wire logic [WAKE_CNT_W-1:0] stopDelay  = (flashDelay > lpDelay) ? flashDelay : lpDelay;

   always_comb
   begin
      mode_d    = mode_q;
      wakeCnt_d = wakeCnt_q;
      case (mode_q)
         PMC_RUN:
         begin
            if (cpuWaitReq)
            begin
               if (!cpuDeepSleep)
                  mode_d = PMC_SLEEP;
               else if (pdds_q)
                  mode_d = PMC_STANDBY;
               else
                  mode_d = PMC_STOP;
            end
         end
         PMC_SLEEP:
         begin
            if (irqAck | eventLineAny)
               mode_d = PMC_RUN;
         end
         PMC_STOP:
         begin
            if (eventLineAny)
            begin
               wakeCnt_d = stopDelay;
               mode_d    = (stopDelay == '0) ? PMC_RUN : PMC_WAKE;
            end
         end
         PMC_STANDBY:
         begin
            if (standbyExit)
               mode_d = PMC_RUN;
         end
         PMC_WAKE:
         begin
            wakeCnt_d = wakeCnt_q - WAKE_CNT_W'(1);
            if (wakeCnt_q == WAKE_CNT_W'(1))
               mode_d = PMC_RUN;
         end
         default:
            mode_d = PMC_RUN;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         mode_q    <= PMC_RUN;
         wakeCnt_q <= '0;
      end
      else
      begin
         mode_q    <= mode_d;
         wakeCnt_q <= wakeCnt_d;
      end
   end

   // Control register
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || ctrlDefault)
      begin
         stopLp_q  <= CTRL_RESET[CTRL_STOP_LP_BIT];
         pdds_q    <= CTRL_RESET[CTRL_PDDS_BIT];
         pvde_q    <= CTRL_RESET[CTRL_PVDE_BIT];
         level_q   <= LEVEL_RESET;
         dbp_q     <= CTRL_RESET[CTRL_DBP_BIT];
         flashPd_q <= CTRL_RESET[CTRL_FLASH_PD_BIT];
      end
      else if (wrCtrl)
      begin
         stopLp_q  <= pwdata[CTRL_STOP_LP_BIT];
         pdds_q    <= pwdata[CTRL_PDDS_BIT];
         pvde_q    <= pwdata[CTRL_PVDE_BIT];
         level_q   <= pwdata[CTRL_LEVEL_LSB +: CTRL_LEVEL_W];
         dbp_q     <= pwdata[CTRL_DBP_BIT];
         flashPd_q <= pwdata[CTRL_FLASH_PD_BIT];
      end
   end

   // Status flags and status-register controls
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || periphReset)
      begin
         wakeFlag_q <= STAT_RESET[STAT_WAKE_FLAG_BIT];
         stbyFlag_q <= STAT_RESET[STAT_STBY_FLAG_BIT];
         pinEn_q    <= STAT_RESET[STAT_PIN_EN_BIT];
         bre_q      <= STAT_RESET[STAT_BRE_BIT];
      end
      else
      begin
         if (wakeEvent)
            wakeFlag_q <= 1'b1;
         else if (clrWake)
            wakeFlag_q <= 1'b0;
         if (leaveStandby)
            stbyFlag_q <= 1'b1;
         else if (clrStby)
            stbyFlag_q <= 1'b0;
         if (wrStat)
         begin
            pinEn_q <= pwdata[STAT_PIN_EN_BIT];
            bre_q  <= pwdata[STAT_BRE_BIT];
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         pinLast_q <= 1'b0;
      else
         pinLast_q <= wakePin;
   end

   // Read data is caught in the setup phase so the access phase needs no wait
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         rdata_q <= '0;
      else if (setupPhase & ~pwrite)
         rdata_q <= readMux;
   end

   assign prdata  = rdata_q;
   assign pready  = 1'b1;
   assign pslverr = accessPhase & ~hitAny;

   // Analog and system controls
   assign detectLevelSel    = level_q;
   assign detectorEnable    = detActive;
   assign eventLine16       = detFlag;
   assign wakePinPullDown   = pinEn_q;
   assign backupRegEnable   = bre_q;
   assign backupWriteEnable = dbp_q;
   // Tamper inputs are deliberately not wired here
   assign backupSramErase   = rdpDowngradeReq;
   assign powerMode         = mode_q;

   // Stop keeps the regulator on unless low power is chosen; Standby cuts it
   assign powerCtl.coreHalt       = (mode_q != PMC_RUN);
   assign powerCtl.clkDomainStop  = (mode_q == PMC_STOP) | (mode_q == PMC_STANDBY);
   assign powerCtl.pllOscOff      = (mode_q == PMC_STOP) | (mode_q == PMC_STANDBY);
   assign powerCtl.regLowPower    = (mode_q == PMC_STOP) & stopLp_q;
   assign powerCtl.regOff         = (mode_q == PMC_STANDBY);
   assign powerCtl.flashPowerDown = ((mode_q == PMC_STOP) | (mode_q == PMC_WAKE)) & flashPd_q;

endmodule : pmc_power_mode_controller

// ---- core/pmc_pkg.sv ----
// Power mode controller package: register map, field positions, reset values,
// mode states, timing constants and the packed control bundle.
// Assumes a 200 MHz system clock and 32-bit register data.
package pmc_pkg;

   // Register byte offsets
   localparam logic [7:0]  OFS_CTRL        = 8'h00;
   localparam logic [7:0]  OFS_CTRL_STAT   = 8'h04;

   // Control register field positions
   localparam int          CTRL_STOP_LP_BIT = 0;
   localparam int          CTRL_PDDS_BIT   = 1;
   localparam int          CTRL_CWUF_BIT   = 2;
   localparam int          CTRL_CSBF_BIT   = 3;
   localparam int          CTRL_PVDE_BIT   = 4;
   localparam int          CTRL_LEVEL_LSB  = 5;
   localparam int          CTRL_LEVEL_W    = 3;
   localparam int          CTRL_DBP_BIT    = 8;
   localparam int          CTRL_FLASH_PD_BIT = 9;

   // Control/status register field positions
   localparam int          STAT_WAKE_FLAG_BIT = 0;
   localparam int          STAT_STBY_FLAG_BIT = 1;
   localparam int          STAT_DET_FLAG_BIT  = 2;
   localparam int          STAT_READY_BIT     = 3;
   localparam int          STAT_PIN_EN_BIT    = 8;
   localparam int          STAT_BRE_BIT    = 9;

   // Values after reset
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
   localparam logic [31:0] STAT_RESET      = 32'h0000_0000;
   localparam logic [2:0]  LEVEL_RESET     = 3'h0;

   // Wake-up startup delays out of Stop
   localparam int          CLK_PERIOD_NS   = 5;
   localparam int          FLASH_WAKE_NS   = 1000;
   localparam int          LPREG_WAKE_NS   = 500;
   localparam int          FLASH_WAKE_CYC  = (FLASH_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          LPREG_WAKE_CYC  = (LPREG_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          WAKE_CNT_W      = 12;

   // Number of detector threshold levels, 2.0V up to 3.0V
   localparam int          DET_LEVELS      = 8;

   typedef enum logic [2:0] {
      PMC_RUN,
      PMC_SLEEP,
      PMC_STOP,
      PMC_STANDBY,
      PMC_WAKE
   } pmc_mode_t;

   // Controls toward clock, supply and flash logic
   typedef struct packed {
      logic coreHalt;
      logic clkDomainStop;
      logic pllOscOff;
      logic regLowPower;
      logic regOff;
      logic flashPowerDown;
   } pmc_power_t;

   // Standby exit sources
   typedef struct packed {
      logic rtcAlarmA;
      logic rtcAlarmB;
      logic rtcWakeup;
      logic rtcTamper;
      logic rtcTimeStamp;
      logic resetPin;
      logic watchdogReset;
   } pmc_wake_src_t;

endpackage : pmc_pkg

// ---- testbench/pmc_properties.sv ----
// Port-level properties of the power mode controller.
// Assumes binding onto pmc_power_mode_controller, one clock domain.
`timescale 1ns/1ps
module pmc_properties
   import pmc_pkg::*;
#(
   parameter int ADDR_W = 8
)(
   input wire logic                  clk_sys,
   input wire logic                  rst_n,
   input wire logic                  periphReset,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [ADDR_W-1:0]     paddr,
   input wire logic [31:0]           pwdata,
   input wire logic                  cpuWaitReq,
   input wire logic                  cpuDeepSleep,
   input wire logic                  irqAck,
   input wire logic                  eventLineAny,
   input wire pmc_wake_src_t         wakeSrc,
   input wire logic [DET_LEVELS-1:0] supplyAbove,
   input wire logic                  rdpDowngradeReq,
   input wire logic [2:0]            detectLevelSel,
   input wire logic                  detectorEnable,
   input wire logic                  eventLine16,
   input wire logic                  backupWriteEnable,
   input wire logic                  backupSramErase,
   input wire pmc_power_t            powerCtl,
   input wire pmc_mode_t             powerMode
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Peripheral reset excluded: it overrides a same-cycle write
   wire       ctrlWr = psel && penable && pwrite && paddr == ADDR_W'(OFS_CTRL) && !periphReset;
   wire       dbpWr = ctrlWr && pwdata[CTRL_DBP_BIT];
   wire [2:0] wrLevel = pwdata[CTRL_LEVEL_LSB +: CTRL_LEVEL_W];
   sequence sleepReq;
      powerMode == PMC_RUN && cpuWaitReq && !cpuDeepSleep;
   endsequence
   sequence stopExit;
      powerMode == PMC_STOP && eventLineAny;
   endsequence
   AST_BKP_GATE: assert property ($rose(backupWriteEnable) |-> $past(dbpWr))
      else $error("backup write enable rose without a control write");
   AST_LEVEL: assert property (ctrlWr && powerMode == PMC_RUN |=> detectLevelSel == $past(wrLevel))
      else $error("level select does not follow written value");
   AST_FLAG16: assert property (detectorEnable |-> eventLine16 == !supplyAbove[detectLevelSel])
      else $error("event line 16 does not match selected threshold");
   AST_DET_HALT: assert property (powerMode == PMC_STANDBY |-> !detectorEnable)
      else $error("detector running in standby");
   AST_SLEEP_IN: assert property (sleepReq |=> powerMode == PMC_SLEEP && powerCtl.coreHalt)
      else $error("sleep not entered");
   AST_SLEEP_OUT: assert property (powerMode == PMC_SLEEP && irqAck |=> powerMode == PMC_RUN)
      else $error("sleep not left on interrupt");
   AST_STOP_CLK: assert property (powerMode == PMC_STOP |-> powerCtl.clkDomainStop && powerCtl.pllOscOff)
      else $error("clocks running in stop");
   AST_STOP_OUT: assert property (stopExit |=> powerMode inside {PMC_WAKE, PMC_RUN})
      else $error("stop not left on event");
   AST_STBY_REG: assert property (powerMode == PMC_STANDBY |-> powerCtl.regOff)
      else $error("regulator on in standby");
   AST_STBY_OUT: assert property (powerMode == PMC_STANDBY && (|wakeSrc) |=> powerMode != PMC_STANDBY)
      else $error("standby not left on wake source");
   AST_ERASE: assert property (backupSramErase == rdpDowngradeReq)
      else $error("backup erase not tied to protection downgrade");
endmodule : pmc_properties

bind pmc_power_mode_controller pmc_properties #(.ADDR_W(ADDR_W)) u_pmc_properties (
   .clk_sys, .rst_n, .periphReset, .psel, .penable, .pwrite, .paddr, .pwdata, .cpuWaitReq,
   .cpuDeepSleep, .irqAck, .eventLineAny, .wakeSrc, .supplyAbove, .rdpDowngradeReq,
   .detectLevelSel, .detectorEnable, .eventLine16, .backupWriteEnable, .backupSramErase,
   .powerCtl, .powerMode);

// ---- testbench/pmc_power_mode_controller_tb_top.sv ----
// Self-checking bench for the power mode controller.
// Assumes a bus with no wait states and short wake counts (3 and 2).
`timescale 1ns/1ps
module pmc_power_mode_controller_tb_top
   import pmc_pkg::*;
;
   localparam logic [31:0] RDY = 32'h1 << STAT_READY_BIT;
   localparam logic [31:0] PINEN = 32'h1 << STAT_PIN_EN_BIT;
   localparam logic [31:0] FLG = 32'h3;
   localparam logic [31:0] ON = (32'h1 << CTRL_PVDE_BIT) | (32'h1 << CTRL_DBP_BIT);
   logic          clk_sys = 1'h0, rst_n = 1'h0, periphReset = 1'h0;
   logic          psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0]    paddr = 8'h00, supplyAbove = 8'h0f;
   logic [31:0]   pwdata = 32'h0, prdata, rdData;
   logic          pready, pslverr, rdErr, eventLine16, wakePinPullDown;
   logic          cpuWaitReq = 1'h0, cpuDeepSleep = 1'h0, irqAck = 1'h0, eventLineAny = 1'h0;
   logic          wakePin = 1'h0, backupRegReadyIn = 1'h0, rdpDowngradeReq = 1'h0;
   logic [2:0]    detectLevelSel;
   logic          detectorEnable, backupRegEnable, backupWriteEnable, backupSramErase;
   pmc_wake_src_t wakeSrc = '0;
   pmc_power_t    powerCtl;
   pmc_mode_t     powerMode;
   int            num_errors = 0, num_checks = 0, n;

   pmc_power_mode_controller #(.FLASH_WAKE(3), .LPREG_WAKE(2)) u_pmc_power_mode_controller (
      .clk_sys, .rst_n, .periphReset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .cpuWaitReq, .cpuDeepSleep, .irqAck, .eventLineAny, .wakePin,
      .wakeSrc, .supplyAbove, .backupRegReadyIn, .rdpDowngradeReq, .detectLevelSel,
      .detectorEnable, .eventLine16, .wakePinPullDown, .backupRegEnable, .backupWriteEnable,
      .backupSramErase, .powerCtl, .powerMode);

   initial
   begin
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Ready is always high, so the access phase is one cycle
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(negedge clk_sys);
      psel = 1'h1;
      pwrite = wr;
      paddr = a;
      pwdata = d;
      @(negedge clk_sys);
      penable = 1'h1;
      @(posedge clk_sys);
      rdData = prdata;
      rdErr = pslverr;
      @(negedge clk_sys);
      psel = 1'h0;
      penable = 1'h0;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'h1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'h0, a, 32'h0);
      chk(rdData, exp);
   endtask : rd

   task automatic pulse(ref logic s);
      @(negedge clk_sys);
      s = 1'h1;
      @(negedge clk_sys);
      s = 1'h0;
   endtask : pulse

   task automatic req(input logic deep);
      cpuDeepSleep = deep;
      pulse(cpuWaitReq);
   endtask : req

   task automatic do_reset;
      rst_n = 1'h0;
      repeat (5) @(negedge clk_sys);
      rst_n = 1'h1;
   endtask : do_reset

   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : report_and_stop

   // Tests need well under 1000 cycles; allow ten times that
   initial
   begin
      #50000;
      num_errors++;
      report_and_stop;
   end

   initial
   begin
      do_reset;
      rd(OFS_CTRL, CTRL_RESET);
      rd(OFS_CTRL_STAT, STAT_RESET);
      chk(32'(backupWriteEnable), 32'h0);
      backupRegReadyIn = 1'h1;
      do_reset;
      rd(OFS_CTRL_STAT, RDY);
      rd(8'h08, 32'h0);
      chk(32'(rdErr), 32'h1);
      chk(32'(pready), 32'h1);
      $display("test reset done");
      for (n = 0; n < DET_LEVELS; n++)
      begin
         wr(OFS_CTRL, (32'(n) << CTRL_LEVEL_LSB) | ON);
         chk(32'(detectLevelSel), 32'(n));
         chk(32'(eventLine16), 32'(n >= 4));
      end
      chk(32'(backupWriteEnable), 32'h1);
      rd(OFS_CTRL_STAT, RDY | 32'h4);
      $display("test detector done");
      req(1'h0);
      chk(32'(powerMode), 32'(PMC_SLEEP));
      pulse(irqAck);
      chk(32'(powerMode), 32'(PMC_RUN));
      wr(OFS_CTRL, (32'h1 << CTRL_FLASH_PD_BIT) | (32'h1 << CTRL_STOP_LP_BIT));
      req(1'h1);
      chk(32'(powerMode), 32'(PMC_STOP));
      chk(32'({powerCtl.flashPowerDown, powerCtl.regLowPower}), 32'h3);
      pulse(eventLineAny);
      n = 0;
      while (powerMode == PMC_WAKE && n < 50)
      begin
         @(negedge clk_sys);
         n++;
      end
      chk(32'(n), 32'h3);
      chk(32'(powerMode), 32'(PMC_RUN));
      $display("test sleep stop done");
      wr(OFS_CTRL_STAT, PINEN);
      chk(32'(wakePinPullDown), 32'h1);
      wr(OFS_CTRL, (32'h1 << CTRL_PDDS_BIT) | ON);
      req(1'h1);
      chk(32'(powerMode), 32'(PMC_STANDBY));
      chk(32'({powerCtl.regOff, detectorEnable}), 32'h2);
      pulse(wakePin);
      chk(32'(powerMode == PMC_STANDBY), 32'h0);
      rd(OFS_CTRL_STAT, RDY | PINEN | FLG);
      rd(OFS_CTRL, CTRL_RESET);
      for (n = 0; n < $bits(pmc_wake_src_t); n++)
      begin
         wr(OFS_CTRL, 32'h1 << CTRL_PDDS_BIT);
         req(1'h1);
         chk(32'(powerMode), 32'(PMC_STANDBY));
         wakeSrc = pmc_wake_src_t'(7'h1 << n);
         @(negedge clk_sys);
         wakeSrc = '0;
         chk(32'(powerMode == PMC_STANDBY), 32'h0);
         chk(32'(backupSramErase), 32'h0);
      end
      $display("test standby done");
      wr(OFS_CTRL_STAT, 32'h0);
      wr(OFS_CTRL, 32'h1 << CTRL_CWUF_BIT);
      rd(OFS_CTRL_STAT, RDY | 32'h2);
      wakePin = 1'h1;
      wr(OFS_CTRL_STAT, PINEN);
      rd(OFS_CTRL_STAT, RDY | PINEN | FLG);
      wr(OFS_CTRL, 32'h1 << CTRL_CSBF_BIT);
      rd(OFS_CTRL_STAT, RDY | PINEN | 32'h1);
      rdpDowngradeReq = 1'h1;
      @(negedge clk_sys);
      chk(32'(backupSramErase), 32'h1);
      wr(OFS_CTRL, ON | (32'h1 << CTRL_FLASH_PD_BIT));
      wr(OFS_CTRL_STAT, 32'h1 << STAT_BRE_BIT);
      chk(32'(backupRegEnable), 32'h1);
      pulse(periphReset);
      chk(32'(backupRegEnable), 32'h0);
      rd(OFS_CTRL, CTRL_RESET);
      rd(OFS_CTRL_STAT, RDY);
      $display("test flags deinit done");
      report_and_stop;
   end
endmodule : pmc_power_mode_controller_tb_top
